/* File: rtl/csfb_flag_bank.sv */
// top of the controller status flag bank
`timescale 1ns/1ps
module csfb_flag_bank #(
    parameter int unsigned TICK_CYC = csfb_pkg::TICK_MS_CYC,
    parameter int unsigned DATA_W = csfb_pkg::DATA_W,
    parameter int unsigned CNT_W = csfb_pkg::SCAN_CNT_W
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    // cpu state, same clock domain
    input wire logic [1:0] MODE_IN,
    input wire logic REMOTE_IN,
    input wire logic STOP_EXEC_IN,
    input wire logic SCAN_END_IN,
    // error events and levels
    input wire logic FATAL_ERR_IN,
    input wire logic WARN_ERR_IN,
    input wire logic SCAN_WATCHDOG_EXP_IN,
    input wire logic ERR_CLR_IN,
    input wire logic [31:0] IO_CHANGE_IN,
    input wire logic IO_ERR_CLR_IN,
    input wire logic BATT_LOW_PIN_IN,
    input wire logic BACKUP_OK_IN,
    input wire logic RTC_BAD_WRITE_IN,
    input wire logic EDIT_ACTIVE_IN,
    input wire logic EDIT_FAIL_IN,
    input wire logic ERR_CODE_WE_IN,
    input wire logic [15:0] ERR_CODE_IN,
    // user clock setup instruction
    input wire logic UCLK_LOAD_IN,
    input wire logic [2:0] UCLK_SEL_IN,
    input wire logic [CNT_W-1:0] UCLK_N1_IN,
    input wire logic [CNT_W-1:0] UCLK_N2_IN,
    // arithmetic result strobe
    input wire logic ALU_DONE_IN,
    input wire logic ALU_ERR_IN,
    input wire logic [DATA_W-1:0] ALU_RESULT_IN,
    input wire logic ALU_CARRY_IN,
    input wire logic OP_ERR_LATCH_CLR_IN,
    input wire logic OUTPUTS_OFF_EXEC_IN,
    // compare instruction strobe
    input wire logic COMPARE_INSTRUCTION_IN,
    input wire logic COMPARE_SIGNED_IN,
    input wire logic [DATA_W-1:0] CMP_S1_IN,
    input wire logic [DATA_W-1:0] CMP_S2_IN,
    // flag outputs
    output logic RUN_MODE_OUT,
    output logic PROGRAM_MODE_OUT,
    output logic PAUSE_MODE_OUT,
    output logic REMOTE_MODE_OUT,
    output logic STOP_EXEC_OUT,
    output logic ALWAYS_ON_OUT,
    output logic ALWAYS_OFF_OUT,
    output logic FIRST_SCAN_ON_OUT,
    output logic FIRST_SCAN_OFF_OUT,
    output logic SCAN_TOGGLE_OUT,
    output logic FATAL_ERR_OUT,
    output logic WARN_ERR_OUT,
    output logic SCAN_WATCHDOG_ERR_OUT,
    output logic IO_ERR_ANY_OUT,
    output logic BATT_FAULT_OUT,
    output logic BACKUP_GOOD_OUT,
    output logic CAL_DATA_ERR_OUT,
    output logic EDIT_ACTIVE_OUT,
    output logic EDIT_ERR_OUT,
    output logic [31:0] IO_ERR_OUT,
    output logic [15:0] ERR_CODE_OUT,
    output logic [7:0] CYCLE_CLK_OUT,
    output logic [7:0] USER_CLK_OUT,
    output logic OP_ERR_OUT,
    output logic ZERO_OUT,
    output logic CARRY_OUT,
    output logic OUTPUTS_OFF_OUT,
    output logic OP_ERR_LATCH_OUT,
    output logic COMPARE_LESS_OUT,
    output logic COMPARE_LESS_OR_SAME_OUT,
    output logic COMPARE_SAME_OUT,
    output logic COMPARE_GREATER_OUT,
    output logic COMPARE_GREATER_OR_SAME_OUT,
    output logic COMPARE_NOT_SAME_OUT
);
    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    // last count of a half period of a square wave, in 1 ms ticks
    function automatic logic [15:0] csfb_half(input int unsigned period_ms);
        csfb_half = 16'((period_ms / 2) - 1);
    endfunction

    // signed or unsigned less-than used by the lt, le, gt and ge compare flags
    function automatic logic csfb_less(input logic [DATA_W-1:0] a,
                                       input logic [DATA_W-1:0] b,
                                       input logic sgn);
        if (sgn) begin
            csfb_less = $signed(a) < $signed(b);
        end else begin
            csfb_less = a < b;
        end
    endfunction

    localparam logic [15:0] HALF_TAB [8] = '{
        csfb_half(csfb_pkg::PER_20MS), csfb_half(csfb_pkg::PER_100MS),
        csfb_half(csfb_pkg::PER_200MS), csfb_half(csfb_pkg::PER_1S),
        csfb_half(csfb_pkg::PER_2S), csfb_half(csfb_pkg::PER_10S),
        csfb_half(csfb_pkg::PER_20S), csfb_half(csfb_pkg::PER_60S)};

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef struct packed {
        logic batt_meta;
        logic batt_sync;
        logic [2:0] mode_hot;
        logic remote;
        logic stop;
        logic first_scan;
        logic first_off;
        logic toggle;
        logic fatal;
        logic warn;
        logic wdog;
        logic [31:0] io_err;
        logic io_any;
        logic batt;
        logic backup;
        logic cal_err;
        logic edit;
        logic edit_err;
        logic [15:0] err_code;
        logic [23:0] tick_cnt;
        logic [7:0][15:0] wave_cnt;
        logic [7:0] wave;
        logic op_err;
        logic zero;
        logic carry;
        logic outs_off;
        logic op_latch;
        logic [5:0] cmp;
    } csfb_state_t;

    csfb_state_t st_reg;
    csfb_state_t st_next;
    logic tick_ms;
    logic [7:0] uclk;
    logic cmp_lt;
    logic cmp_eq;

    assign tick_ms = (st_reg.tick_cnt == 24'(TICK_CYC - 1));
    assign cmp_lt = csfb_less(CMP_S1_IN, CMP_S2_IN, COMPARE_SIGNED_IN);
    assign cmp_eq = (CMP_S1_IN == CMP_S2_IN);

    // ----------------------------------------------------------
    // user clocks
    // ----------------------------------------------------------
    // each instance is loaded only when the setup instruction selects it
    for (genvar g = 0; g < 8; g++) begin : g_uclk
        csfb_user_clock #(
            .CNT_W(CNT_W)
        ) u_uclk (
            .clk_in(SYS_CLK_IN),
            .rst_n_in(RST_N_IN),
            .scan_end_in(SCAN_END_IN),
            .load_in(UCLK_LOAD_IN && (UCLK_SEL_IN == 3'(g))),
            .n1_in(UCLK_N1_IN),
            .n2_in(UCLK_N2_IN),
            .flag_out(uclk[g])
        );
    end

    // ----------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // battery monitor level arrives from a pin, two stages first
        st_next.batt_meta = BATT_LOW_PIN_IN;
        st_next.batt_sync = st_reg.batt_meta;
        st_next.batt = st_reg.batt_sync;
        // mode and status levels follow their sources
        st_next.mode_hot[0] = (MODE_IN == 2'(csfb_pkg::CSFB_MODE_RUN));
        st_next.mode_hot[1] = (MODE_IN == 2'(csfb_pkg::CSFB_MODE_PROGRAM));
        st_next.mode_hot[2] = (MODE_IN == 2'(csfb_pkg::CSFB_MODE_PAUSE));
        st_next.remote = REMOTE_IN;
        st_next.stop = STOP_EXEC_IN;
        st_next.backup = BACKUP_OK_IN;
        st_next.edit = EDIT_ACTIVE_IN;
        // scan-based flags
        if (SCAN_END_IN) begin
            st_next.first_scan = 1'b0;
            st_next.first_off = 1'b1;
            st_next.toggle = ~st_reg.toggle;
        end
        // error flags are sticky; a new event wins over a clear
        if (ERR_CLR_IN) begin
            st_next.fatal = 1'b0;
            st_next.warn = 1'b0;
            st_next.wdog = 1'b0;
            st_next.cal_err = 1'b0;
            st_next.edit_err = 1'b0;
        end
        if (FATAL_ERR_IN) begin
            st_next.fatal = 1'b1;
        end
        if (WARN_ERR_IN) begin
            st_next.warn = 1'b1;
        end
        if (SCAN_WATCHDOG_EXP_IN) begin
            st_next.wdog = 1'b1;
        end
        if (RTC_BAD_WRITE_IN) begin
            st_next.cal_err = 1'b1;
        end
        if (EDIT_FAIL_IN) begin
            st_next.edit_err = 1'b1;
        end
        // per-module field, insertion or removal marks the slot
        st_next.io_err = (IO_ERR_CLR_IN ? 32'h0000_0000 : st_reg.io_err)
            | IO_CHANGE_IN;
        st_next.io_any = |st_next.io_err;
        if (ERR_CODE_WE_IN) begin
            st_next.err_code = ERR_CODE_IN;
        end
        // millisecond base and square waves
        st_next.tick_cnt = tick_ms ? 24'h00_0000 : st_reg.tick_cnt + 24'h00_0001;
        if (tick_ms) begin
            for (int i = 0; i < 8; i++) begin
                if (st_reg.wave_cnt[i] == HALF_TAB[i]) begin
                    st_next.wave_cnt[i] = 16'h0000;
                    st_next.wave[i] = ~st_reg.wave[i];
                end else begin
                    st_next.wave_cnt[i] = st_reg.wave_cnt[i] + 16'h0001;
                end
            end
        end
        // arithmetic result flags update on each completed operation
        if (ALU_DONE_IN) begin
            st_next.op_err = ALU_ERR_IN;
            st_next.zero = (ALU_RESULT_IN == '0);
            st_next.carry = ALU_CARRY_IN;
        end
        if (OP_ERR_LATCH_CLR_IN) begin
            st_next.op_latch = 1'b0;
        end
        if (ALU_DONE_IN && ALU_ERR_IN) begin
            st_next.op_latch = 1'b1;
        end
        if (OUTPUTS_OFF_EXEC_IN) begin
            st_next.outs_off = 1'b1;
        end
        // compare flags: lt, le, eq, gt, ge, ne
        if (COMPARE_INSTRUCTION_IN) begin
            st_next.cmp[0] = cmp_lt;
            st_next.cmp[1] = cmp_lt | cmp_eq;
            st_next.cmp[2] = cmp_eq;
            st_next.cmp[3] = ~cmp_lt & ~cmp_eq;
            st_next.cmp[4] = ~cmp_lt;
            st_next.cmp[5] = ~cmp_eq;
        end
    end

    // ----------------------------------------------------------
    // state register
    // ----------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_reg <= '0;
            st_reg.mode_hot[1] <= 1'b1;
            st_reg.first_scan <= 1'b1;
            st_reg.io_err <= csfb_pkg::IO_ERR_RST;
            st_reg.err_code <= csfb_pkg::ERR_CODE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // user clock flags registered again so every output but the two constants is a flop
    logic [7:0] uclk_reg;
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            uclk_reg <= 8'h00;
        end else begin
            uclk_reg <= uclk;
        end
    end

    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    // mode flags are own flops; code 3 shows none
    assign RUN_MODE_OUT = st_reg.mode_hot[0];
    assign PROGRAM_MODE_OUT = st_reg.mode_hot[1];
    assign PAUSE_MODE_OUT = st_reg.mode_hot[2];
    assign REMOTE_MODE_OUT = st_reg.remote;
    assign STOP_EXEC_OUT = st_reg.stop;
    assign ALWAYS_ON_OUT = 1'b1;
    assign ALWAYS_OFF_OUT = 1'b0;
    assign FIRST_SCAN_ON_OUT = st_reg.first_scan;
    assign FIRST_SCAN_OFF_OUT = st_reg.first_off;
    assign SCAN_TOGGLE_OUT = st_reg.toggle;
    assign FATAL_ERR_OUT = st_reg.fatal;
    assign WARN_ERR_OUT = st_reg.warn;
    assign SCAN_WATCHDOG_ERR_OUT = st_reg.wdog;
    assign IO_ERR_ANY_OUT = st_reg.io_any;
    assign BATT_FAULT_OUT = st_reg.batt;
    assign BACKUP_GOOD_OUT = st_reg.backup;
    assign CAL_DATA_ERR_OUT = st_reg.cal_err;
    assign EDIT_ACTIVE_OUT = st_reg.edit;
    assign EDIT_ERR_OUT = st_reg.edit_err;
    assign IO_ERR_OUT = st_reg.io_err;
    assign ERR_CODE_OUT = st_reg.err_code;
    assign CYCLE_CLK_OUT = st_reg.wave;
    assign USER_CLK_OUT = uclk_reg;
    assign OP_ERR_OUT = st_reg.op_err;
    assign ZERO_OUT = st_reg.zero;
    assign CARRY_OUT = st_reg.carry;
    assign OUTPUTS_OFF_OUT = st_reg.outs_off;
    assign OP_ERR_LATCH_OUT = st_reg.op_latch;
    assign COMPARE_LESS_OUT = st_reg.cmp[0];
    assign COMPARE_LESS_OR_SAME_OUT = st_reg.cmp[1];
    assign COMPARE_SAME_OUT = st_reg.cmp[2];
    assign COMPARE_GREATER_OUT = st_reg.cmp[3];
    assign COMPARE_GREATER_OR_SAME_OUT = st_reg.cmp[4];
    assign COMPARE_NOT_SAME_OUT = st_reg.cmp[5];
endmodule

/* File: rtl/csfb_pkg.sv */
// package of constants for the controller status flag bank
package csfb_pkg;
    // --------------------------------------------------------------
    // timing base
    // --------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned TICK_MS_HZ = 1000;
    // cycles per 1 ms tick, rounded down (shortest time)
    localparam int unsigned TICK_MS_CYC = CLK_HZ / TICK_MS_HZ;
    // square-wave periods in ms, bit 0 is the fastest
    localparam int unsigned PER_20MS = 20;
    localparam int unsigned PER_100MS = 100;
    localparam int unsigned PER_200MS = 200;
    localparam int unsigned PER_1S = 1000;
    localparam int unsigned PER_2S = 2000;
    localparam int unsigned PER_10S = 10000;
    localparam int unsigned PER_20S = 20000;
    localparam int unsigned PER_60S = 60000;
    localparam int unsigned NUM_WAVES = 8;
    localparam int unsigned NUM_USER_CLK = 8;
    localparam int unsigned IO_ERR_W = 32;
    localparam int unsigned ERR_CODE_W = 16;
    localparam int unsigned SCAN_CNT_W = 16;
    localparam int unsigned DATA_W = 16;
    // reset values
    localparam logic [15:0] ERR_CODE_RST = 16'h0000;
    localparam logic [31:0] IO_ERR_RST = 32'h0000_0000;
    // operating modes
    typedef enum logic [1:0] {
        CSFB_MODE_PROGRAM,
        CSFB_MODE_RUN,
        CSFB_MODE_PAUSE
    } csfb_mode_t;
endpackage

/* File: rtl/csfb_user_clock.sv */
// one user clock flag: high n1 scans, low n2 scans, repeating
`timescale 1ns/1ps
module csfb_user_clock #(
    parameter int unsigned CNT_W = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic scan_end_in,
    input wire logic load_in,
    input wire logic [CNT_W-1:0] n1_in,
    input wire logic [CNT_W-1:0] n2_in,
    output logic flag_out
);
    typedef struct packed {
        logic [CNT_W-1:0] n1;
        logic [CNT_W-1:0] n2;
        logic [CNT_W-1:0] cnt;
        logic level;
        logic active;
    } csfb_uclk_t;

    csfb_uclk_t st_reg;
    csfb_uclk_t st_next;

    // ----------------------------------------------------------
    // scan counting
    // ----------------------------------------------------------
    // a zero count is treated as one scan so the flag never stalls
    always_comb begin
        st_next = st_reg;
        if (load_in) begin
            st_next.n1 = n1_in;
            st_next.n2 = n2_in;
            st_next.cnt = '0;
            st_next.level = 1'b1;
            st_next.active = 1'b1;
        end else if (scan_end_in && st_reg.active) begin
            if (st_reg.level) begin
                if ((st_reg.cnt + 1'b1) >= st_reg.n1) begin
                    st_next.level = 1'b0;
                    st_next.cnt = '0;
                end else begin
                    st_next.cnt = st_reg.cnt + 1'b1;
                end
            end else begin
                if ((st_reg.cnt + 1'b1) >= st_reg.n2) begin
                    st_next.level = 1'b1;
                    st_next.cnt = '0;
                end else begin
                    st_next.cnt = st_reg.cnt + 1'b1;
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag_out = st_reg.level;
endmodule

/* File: sim/csfb_flag_bank_assertions.sv */
// concurrent checks on the ports of the controller status flag bank
`timescale 1ns/1ps
module csfb_flag_bank_assertions #(
    parameter int unsigned TICK_CYC = 4,
    parameter int unsigned DATA_W = 16
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [1:0] MODE_IN,
    input wire logic FATAL_ERR_IN,
    input wire logic ERR_CLR_IN,
    input wire logic WARN_ERR_IN,
    input wire logic [31:0] IO_CHANGE_IN,
    input wire logic BATT_LOW_PIN_IN,
    input wire logic ERR_CODE_WE_IN,
    input wire logic [15:0] ERR_CODE_IN,
    input wire logic ALU_DONE_IN,
    input wire logic ALU_ERR_IN,
    input wire logic [DATA_W-1:0] ALU_RESULT_IN,
    input wire logic ALU_CARRY_IN,
    input wire logic OP_ERR_LATCH_CLR_IN,
    input wire logic RUN_MODE_OUT,
    input wire logic PROGRAM_MODE_OUT,
    input wire logic PAUSE_MODE_OUT,
    input wire logic FATAL_ERR_OUT,
    input wire logic WARN_ERR_OUT,
    input wire logic IO_ERR_ANY_OUT,
    input wire logic [31:0] IO_ERR_OUT,
    input wire logic BATT_FAULT_OUT,
    input wire logic [15:0] ERR_CODE_OUT,
    input wire logic [7:0] CYCLE_CLK_OUT,
    input wire logic ZERO_OUT,
    input wire logic CARRY_OUT,
    input wire logic OP_ERR_LATCH_OUT
);
    // ------------------------------------------------------------
    // helper: cycles between edges of the fastest square wave
    // ------------------------------------------------------------
    logic [31:0] gap_reg;
    logic last_reg;
    logic seen_reg;

    // the first edge after reset has no reference, so it only arms the count
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            gap_reg <= 32'h0;
            last_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else if (CYCLE_CLK_OUT[0] != last_reg) begin
            gap_reg <= 32'h1;
            last_reg <= CYCLE_CLK_OUT[0];
            seen_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    a_run_mode: assert property (MODE_IN == 2'h1 |=> RUN_MODE_OUT && !PROGRAM_MODE_OUT
        && !PAUSE_MODE_OUT) else $error("run mode flags wrong");
    a_fatal_sticky: assert property (FATAL_ERR_IN || (FATAL_ERR_OUT && !ERR_CLR_IN)
        |=> FATAL_ERR_OUT) else $error("fatal flag not set or not held");
    a_warn_set: assert property (WARN_ERR_IN |=> WARN_ERR_OUT)
        else $error("warning flag not set");
    a_io_any: assert property (IO_ERR_ANY_OUT == (|IO_ERR_OUT))
        else $error("combined io flag differs from field");
    a_io_bit_set: assert property ((|IO_CHANGE_IN) |=>
        (IO_ERR_OUT & $past(IO_CHANGE_IN)) == $past(IO_CHANGE_IN)) else $error("io bit not set");
    a_batt_delay: assert property ($rose(BATT_LOW_PIN_IN) ##1 BATT_LOW_PIN_IN[*2]
        |=> BATT_FAULT_OUT) else $error("battery flag late");
    a_err_code: assert property (ERR_CODE_WE_IN |=> ERR_CODE_OUT == $past(ERR_CODE_IN))
        else $error("error code not stored");
    a_wave_half: assert property (CYCLE_CLK_OUT[0] != last_reg && seen_reg
        |-> gap_reg == TICK_CYC * csfb_pkg::PER_20MS / 2) else $error("fast wave half period");
    a_zero_carry: assert property (ALU_DONE_IN |=> ZERO_OUT == ($past(ALU_RESULT_IN) == '0)
        && CARRY_OUT == $past(ALU_CARRY_IN)) else $error("zero or carry flag wrong");
    a_latch_hold: assert property ((ALU_DONE_IN && ALU_ERR_IN)
        || (OP_ERR_LATCH_OUT && !OP_ERR_LATCH_CLR_IN) |=> OP_ERR_LATCH_OUT)
        else $error("latched operation error lost");
endmodule

/* File: sim/tb.sv */
// self-checking bench for the controller status flag bank
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // signals, notes and design
    // ------------------------------------------------------------
    localparam int unsigned TICK = 4;
    typedef struct {int id; logic [31:0] exp; int due;} csfb_note_t;
    csfb_note_t q[$];
    int cyc, n_mismatch, samples_checked;
    logic [31:0] r, e;
    logic [15:0] n1, n2;
    int unsigned h;
    int unsigned per[8] = '{csfb_pkg::PER_20MS, csfb_pkg::PER_100MS, csfb_pkg::PER_200MS,
        csfb_pkg::PER_1S, csfb_pkg::PER_2S, csfb_pkg::PER_10S, csfb_pkg::PER_20S,
        csfb_pkg::PER_60S};
    logic SYS_CLK_IN, RST_N_IN, REMOTE_IN, STOP_EXEC_IN, SCAN_END_IN, FATAL_ERR_IN, WARN_ERR_IN;
    logic SCAN_WATCHDOG_EXP_IN, ERR_CLR_IN, IO_ERR_CLR_IN, BATT_LOW_PIN_IN, BACKUP_OK_IN;
    logic RTC_BAD_WRITE_IN, EDIT_ACTIVE_IN, EDIT_FAIL_IN, ERR_CODE_WE_IN, UCLK_LOAD_IN;
    logic ALU_DONE_IN, ALU_ERR_IN, ALU_CARRY_IN, OP_ERR_LATCH_CLR_IN, OUTPUTS_OFF_EXEC_IN;
    logic COMPARE_INSTRUCTION_IN, COMPARE_SIGNED_IN;
    logic [1:0] MODE_IN;
    logic [2:0] UCLK_SEL_IN;
    logic [15:0] ERR_CODE_IN, UCLK_N1_IN, UCLK_N2_IN, ALU_RESULT_IN, CMP_S1_IN, CMP_S2_IN;
    logic [15:0] ERR_CODE_OUT;
    logic [31:0] IO_CHANGE_IN, IO_ERR_OUT;
    logic [7:0] CYCLE_CLK_OUT, USER_CLK_OUT;
    logic RUN_MODE_OUT, PROGRAM_MODE_OUT, PAUSE_MODE_OUT, REMOTE_MODE_OUT, STOP_EXEC_OUT;
    logic ALWAYS_ON_OUT, ALWAYS_OFF_OUT, FIRST_SCAN_ON_OUT, FIRST_SCAN_OFF_OUT, SCAN_TOGGLE_OUT;
    logic FATAL_ERR_OUT, WARN_ERR_OUT, SCAN_WATCHDOG_ERR_OUT, IO_ERR_ANY_OUT, BATT_FAULT_OUT;
    logic BACKUP_GOOD_OUT, CAL_DATA_ERR_OUT, EDIT_ACTIVE_OUT, EDIT_ERR_OUT, OP_ERR_OUT, ZERO_OUT;
    logic CARRY_OUT, OUTPUTS_OFF_OUT, OP_ERR_LATCH_OUT, COMPARE_LESS_OUT, COMPARE_SAME_OUT;
    logic COMPARE_LESS_OR_SAME_OUT, COMPARE_GREATER_OUT, COMPARE_GREATER_OR_SAME_OUT;
    logic COMPARE_NOT_SAME_OUT;

    // small tick divider keeps every square wave but the 60 s one toggling inside the run
    csfb_flag_bank #(.TICK_CYC(TICK)) i_csfb_flag_bank (.*);

    // ------------------------------------------------------------
    // clock, cycle count, helpers
    // ------------------------------------------------------------
    initial begin
        SYS_CLK_IN = 1'b0;
        forever #50 SYS_CLK_IN = ~SYS_CLK_IN;
    end

    // cycles since reset release, the time base of every note
    always @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) cyc <= 0;
        else cyc <= cyc + 1;
    end

    // groups of outputs that a note can refer to
    function automatic logic [31:0] seen(int id, output string nm);
        nm = $sformatf("group %0d", id);
        case (id)
            0: seen = 32'({REMOTE_MODE_OUT, RUN_MODE_OUT, PROGRAM_MODE_OUT, PAUSE_MODE_OUT,
                STOP_EXEC_OUT, BACKUP_GOOD_OUT, EDIT_ACTIVE_OUT});
            1: seen = 32'({FATAL_ERR_OUT, WARN_ERR_OUT, SCAN_WATCHDOG_ERR_OUT, CAL_DATA_ERR_OUT,
                EDIT_ERR_OUT});
            2: seen = IO_ERR_OUT;
            3: seen = 32'(ERR_CODE_OUT);
            4: seen = 32'({ZERO_OUT, CARRY_OUT, OP_ERR_OUT, OP_ERR_LATCH_OUT, OUTPUTS_OFF_OUT});
            5: seen = 32'({COMPARE_LESS_OUT, COMPARE_LESS_OR_SAME_OUT, COMPARE_SAME_OUT,
                COMPARE_GREATER_OUT, COMPARE_GREATER_OR_SAME_OUT, COMPARE_NOT_SAME_OUT});
            6: seen = 32'({ALWAYS_ON_OUT, ALWAYS_OFF_OUT, FIRST_SCAN_ON_OUT, FIRST_SCAN_OFF_OUT,
                SCAN_TOGGLE_OUT});
            7: seen = 32'({BATT_FAULT_OUT, IO_ERR_ANY_OUT});
            default: seen = (id >= 16) ? 32'(USER_CLK_OUT[id-16]) : 32'(CYCLE_CLK_OUT[id-8]);
        endcase
    endfunction

    // the watcher takes the oldest note once its cycle has come
    always @(negedge SYS_CLK_IN) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            csfb_note_t n;
            string nm;
            logic [31:0] got;
            n = q.pop_front();
            got = seen(n.id, nm);
            samples_checked++;
            if (got !== n.exp) begin
                n_mismatch++;
                $display("wrong value %s: expected %h, seen %h", nm, n.exp, got);
            end
        end
    end

    task automatic note(int id, logic [31:0] exp, int d);
        q.push_back('{id, exp, cyc + d});
    endtask

    // pulses last one edge; an idle cycle follows
    task automatic go(int id, logic [31:0] exp);
        note(id, exp, 1);
        @(negedge SYS_CLK_IN);
        {SCAN_END_IN, FATAL_ERR_IN, WARN_ERR_IN, SCAN_WATCHDOG_EXP_IN, RTC_BAD_WRITE_IN,
            EDIT_FAIL_IN, ERR_CLR_IN, IO_ERR_CLR_IN, ERR_CODE_WE_IN, UCLK_LOAD_IN, ALU_DONE_IN,
            OP_ERR_LATCH_CLR_IN, OUTPUTS_OFF_EXEC_IN, COMPARE_INSTRUCTION_IN, IO_CHANGE_IN} = '0;
        @(negedge SYS_CLK_IN);
    endtask

    task automatic cmp(logic [15:0] a, logic [15:0] b, logic sg);
        logic lt;
        lt = sg ? ($signed(a) < $signed(b)) : (a < b);
        {CMP_S1_IN, CMP_S2_IN, COMPARE_SIGNED_IN, COMPARE_INSTRUCTION_IN} = {a, b, sg, 1'b1};
        go(5, {lt, lt || a == b, a == b, !lt && a != b, !lt, a != b});
    endtask

    task automatic alu(logic [2:0] dce, logic [15:0] res, logic [1:0] clr_off, logic [4:0] x);
        {ALU_DONE_IN, ALU_CARRY_IN, ALU_ERR_IN, ALU_RESULT_IN} = {dce, res};
        {OP_ERR_LATCH_CLR_IN, OUTPUTS_OFF_EXEC_IN} = clr_off;
        go(4, x);
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge SYS_CLK_IN);
        n_mismatch++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        RST_N_IN = 1'b0;
        {MODE_IN, REMOTE_IN, STOP_EXEC_IN, BATT_LOW_PIN_IN, BACKUP_OK_IN, EDIT_ACTIVE_IN} = '0;
        {COMPARE_SIGNED_IN, ALU_ERR_IN, ALU_CARRY_IN, UCLK_SEL_IN, ERR_CODE_IN} = '0;
        {UCLK_N1_IN, UCLK_N2_IN, ALU_RESULT_IN, CMP_S1_IN, CMP_S2_IN} = '0;
        r = $urandom(32'he67d);
        go(2, 0);
        repeat (4) @(negedge SYS_CLK_IN);
        RST_N_IN = 1'b1;
        note(6, 5'h14, 1);
        note(1, 0, 1);
        go(0, 7'h10);
        for (int m = 0; m < 4; m++) begin
            r = $urandom;
            MODE_IN = m[1:0];
            {REMOTE_IN, STOP_EXEC_IN, BACKUP_OK_IN, EDIT_ACTIVE_IN} = r[3:0];
            go(0, {r[3], m == 1, m == 0, m == 2, r[2:0]});
        end
        for (int i = 0; i < 5; i++) begin
            {FATAL_ERR_IN, WARN_ERR_IN, SCAN_WATCHDOG_EXP_IN, RTC_BAD_WRITE_IN, EDIT_FAIL_IN} =
                5'h10 >> i;
            go(1, 32'h1f & ~(32'h1f >> (i + 1)));
        end
        {FATAL_ERR_IN, ERR_CLR_IN} = 2'h3;
        go(1, 5'h10);
        ERR_CLR_IN = 1'b1;
        go(1, 0);
        e = '0;
        for (int i = 0; i < 4; i++) begin
            IO_CHANGE_IN = $urandom & $urandom;
            e = e | IO_CHANGE_IN;
            go(2, e);
        end
        {IO_CHANGE_IN, IO_ERR_CLR_IN} = {32'h8000_0000, 1'b1};
        go(2, 32'h8000_0000);
        IO_ERR_CLR_IN = 1'b1;
        go(2, 0);
        BATT_LOW_PIN_IN = 1'b1;
        go(7, 0);
        go(7, 2'h2);
        BATT_LOW_PIN_IN = 1'b0;
        go(7, 2'h2);
        go(7, 0);
        r = $urandom;
        {ERR_CODE_WE_IN, ERR_CODE_IN} = {1'b1, r[15:0]};
        go(3, r[15:0]);
        ERR_CODE_IN = ~r[15:0];
        go(3, r[15:0]);
        alu(3'h6, 16'h0, 2'h0, 5'h18);
        alu(3'h5, 16'h8001, 2'h0, 5'h06);
        alu(3'h4, 16'h0001, 2'h0, 5'h02);
        alu(3'h0, 16'h0, 2'h3, 5'h01);
        alu(3'h4, 16'h0, 2'h0, 5'h11);
        cmp(16'h3, 16'h5, 1'b0);
        cmp(16'h5, 16'h5, 1'b0);
        cmp(16'hffff, 16'h1, 1'b1);
        cmp(16'hffff, 16'h1, 1'b0);
        for (int i = 0; i < 4; i++) cmp($urandom, $urandom, i[0]);
        SCAN_END_IN = 1'b1;
        go(6, 5'h13);
        SCAN_END_IN = 1'b1;
        go(6, 5'h12);
        for (int k = 0; k < 8; k++) begin
            n1 = 16'(1 + $urandom % 3);
            n2 = 16'(1 + $urandom % 3);
            {UCLK_SEL_IN, UCLK_N1_IN, UCLK_N2_IN, UCLK_LOAD_IN} = {k[2:0], n1, n2, 1'b1};
            go(16 + k, 0);
            note(16 + k, 1, 1);
            for (int j = 1; j <= 2 * (n1 + n2); j++) begin
                SCAN_END_IN = 1'b1;
                go(16 + k, (j - 1) % (n1 + n2) < n1);
                note(16 + k, j % (n1 + n2) < n1, 1);
            end
        end
        for (int c = 0; c < 61000; c++) begin
            for (int i = 0; i < 8; i++) begin
                h = TICK * per[i] / 2;
                if ((cyc + 1) % h == h / 2) note(8 + i, ((cyc + 1) / h) % 2, 1);
            end
            @(negedge SYS_CLK_IN);
        end
        for (int w = 0; w < 10 && q.size() > 0; w++) @(negedge SYS_CLK_IN);
        if (q.size() > 0) n_mismatch++;
        close_out();
    end
endmodule

bind csfb_flag_bank csfb_flag_bank_assertions #(.TICK_CYC(TICK_CYC), .DATA_W(DATA_W))
    i_csfb_flag_bank_assertions (.SYS_CLK_IN, .RST_N_IN, .MODE_IN, .FATAL_ERR_IN, .ERR_CLR_IN,
    .WARN_ERR_IN, .IO_CHANGE_IN, .BATT_LOW_PIN_IN, .ERR_CODE_WE_IN, .ERR_CODE_IN,
    .ALU_DONE_IN, .ALU_ERR_IN, .ALU_RESULT_IN, .ALU_CARRY_IN, .OP_ERR_LATCH_CLR_IN,
    .RUN_MODE_OUT, .PROGRAM_MODE_OUT, .PAUSE_MODE_OUT, .FATAL_ERR_OUT, .WARN_ERR_OUT,
    .IO_ERR_ANY_OUT, .IO_ERR_OUT, .BATT_FAULT_OUT, .ERR_CODE_OUT, .CYCLE_CLK_OUT, .ZERO_OUT,
    .CARRY_OUT, .OP_ERR_LATCH_OUT);
